// >>> common/pidsr_defs.vh
`ifndef PIDSR_DEFS_VH
`define PIDSR_DEFS_VH

// Register byte offsets
`define PIDSR_ADR_CTRL 8'h00
`define PIDSR_ADR_KPCT 8'h04
`define PIDSR_ADR_FBGAIN 8'h08
`define PIDSR_ADR_PGAIN 8'h0c
`define PIDSR_ADR_ITIME 8'h10
`define PIDSR_ADR_DTIME 8'h14
`define PIDSR_ADR_STAT 8'h18
`define PIDSR_ADR_FOUT 8'h1c
`define PIDSR_ADR_ERR 8'h20
`define PIDSR_ADR_INTEG 8'h24

// Control register fields
`define PIDSR_F_SPSEL 2:0
`define PIDSR_F_FBSEL 6:4
`define PIDSR_F_MODE 10:8
`define PIDSR_F_FSRC 15:12
`define PIDSR_CTRL_MASK 32'h0000f777

// Reset values
`define PIDSR_RST_CTRL 32'h00000010
`define PIDSR_RST_KPCT 10'h000
`define PIDSR_RST_FBGAIN 10'h064
`define PIDSR_RST_PGAIN 7'h00
`define PIDSR_RST_ITIME 16'h0000
`define PIDSR_RST_DTIME 10'h000

// Setting limits: pct in 0.1 %, gains in 0.01 / 0.1 %, dtime in 10 ms
`define PIDSR_MAX_KPCT 10'h3e8
`define PIDSR_MAX_FBGAIN 10'h3e8
`define PIDSR_MAX_PGAIN 7'h64
`define PIDSR_MAX_DTIME 10'h3e8

// Source select codes
`define PIDSR_SRC_POT 3'h0
`define PIDSR_SRC_VOLT 3'h1
`define PIDSR_SRC_CURR 3'h2
`define PIDSR_SRC_COMM 3'h3
`define PIDSR_SRC_KPCT 3'h4

// Operation modes and frequency source code for PID control
`define PIDSR_MODE_OFF 3'h0
`define PIDSR_MODE_DEV 3'h1
`define PIDSR_MODE_FB 3'h2
`define PIDSR_MODE_DEVREV 3'h3
`define PIDSR_MODE_FBREV 3'h4
`define PIDSR_FSRC_PID 4'h6

// Scale constants
`define PIDSR_SP_SCALE 32'h00000064
`define PIDSR_I_SCALE 48'h0000000003e8
`define PIDSR_PCT_K 16'h1062
`define PIDSR_PCT_SH 6
`define PIDSR_OUT_K 18'h0a7c6
`define PIDSR_OUT_SH 32
`define PIDSR_FMAX 16'hffff
`define PIDSR_IMAX 33'h07fffffff
`define PIDSR_IMIN 33'h180000000

// Control tick: period in microseconds and clock rate in MHz
`define PIDSR_TICK_US 10000
`define PIDSR_CLK_MHZ 250

`endif

// >>> rtl/pidsr_mul.v
// Signed multiplier, full-width product
module pidsr_mul #(
	parameter AW = 32,
	parameter BW = 16
) (
	input wire signed [AW-1:0] a,
	input wire signed [BW-1:0] b,
	output wire signed [AW+BW-1:0] p
);
	// Operands extended so the product keeps every bit
	wire signed [AW+BW-1:0] a_x;
	wire signed [AW+BW-1:0] b_x;
	assign a_x = {{BW{a[AW-1]}}, a};
	assign b_x = {{AW{b[BW-1]}}, b};
	assign p = a_x * b_x;
endmodule

// >>> rtl/pidsr_top.v
// Notes on behaviour
// - Setpoint select 0 pot, 1 voltage, 2 current, 3 comm, 4 keypad pct.
// - Feedback select 0 pot, 1 voltage, 2 current, 3 comm.
// - Mode 1: derivative is error change over the differentiation time.
// - Mode 2: derivative is feedback change over the differentiation time.
// - Mode 3: error derivative reversed; positive change lowers output.
// - Mode 4: feedback derivative reversed; positive change lowers output.
// - Error is setpoint minus feedback times gain 0.00 to 10.00.
// - Proportional term is error times gain 0.0 to 10.0 percent.
// - Regulator acts only when frequency source code is 6.
// - Integral accumulates error at a rate set by integration time.
// - Differentiation time programmable 0.00 to 10.00 seconds.
//
// The register offsets and the Wishbone slave port are this design's own decisions.
`include "pidsr_defs.vh"
module pidsr_top #(
	parameter TICK_CYCLES = `PIDSR_TICK_US * `PIDSR_CLK_MHZ
) (
	input wire mclk,
	input wire resetn,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire [15:0] keypad_pot,
	input wire [15:0] voltage_analog_input,
	input wire [15:0] current_analog_input,
	input wire [15:0] comm_freq_cmd,
	input wire [15:0] freq_cmd_in,
	output reg [15:0] freq_out_r,
	output reg pid_active_r
);
	localparam ST_IDLE = 3'd0;
	localparam ST_SCALE = 3'd1;
	localparam ST_ERR = 3'd2;
	localparam ST_INT = 3'd3;
	localparam ST_SUM = 3'd4;
	localparam ST_OUT = 3'd5;

	reg [31:0] ctrl_r;
	reg [9:0] kpct_r;
	reg [9:0] fbgain_r;
	reg [6:0] pgain_r;
	reg [15:0] itime_r;
	reg [9:0] dtime_r;
	reg [2:0] state_r;
	reg [31:0] tick_cnt_r;
	reg [15:0] sp_r;
	reg [15:0] fb_r;
	reg [15:0] cmd_r;
	reg signed [31:0] fbk_r;
	reg signed [31:0] err_r;
	reg signed [31:0] integ_r;
	reg [15:0] icnt_r;
	reg [9:0] dcnt_r;
	reg signed [31:0] dprev_r;
	reg signed [31:0] dterm_r;
	reg signed [47:0] ppart_r;
	reg signed [47:0] sum_r;
	reg dvalid_r;
	reg conflict_r;
	reg regulate_r;

	wire [2:0] sp_sel = ctrl_r[`PIDSR_F_SPSEL];
	wire [2:0] fb_sel = ctrl_r[`PIDSR_F_FBSEL];
	wire [2:0] mode = ctrl_r[`PIDSR_F_MODE];
	wire [3:0] fsrc = ctrl_r[`PIDSR_F_FSRC];
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire tick = (tick_cnt_r == TICK_CYCLES - 1);

	// Keypad percentage scaled to full-scale counts
	wire signed [31:0] kpct_p;
	pidsr_mul #(.AW(16), .BW(16)) u_kpct (
		.a({6'h00, kpct_r}),
		.b(`PIDSR_PCT_K),
		.p(kpct_p)
	);
	wire [15:0] kpct_val = kpct_p[`PIDSR_PCT_SH+15:`PIDSR_PCT_SH];

	// Setpoint source select
	reg [15:0] sp_mux;
	always @* begin
		case (sp_sel)
		`PIDSR_SRC_POT: sp_mux = keypad_pot;
		`PIDSR_SRC_VOLT: sp_mux = voltage_analog_input;
		`PIDSR_SRC_CURR: sp_mux = current_analog_input;
		`PIDSR_SRC_COMM: sp_mux = comm_freq_cmd;
		`PIDSR_SRC_KPCT: sp_mux = kpct_val;
		default: sp_mux = 16'h0000;
		endcase
	end

	// Feedback source select
	reg [15:0] fb_mux;
	always @* begin
		case (fb_sel)
		`PIDSR_SRC_POT: fb_mux = keypad_pot;
		`PIDSR_SRC_VOLT: fb_mux = voltage_analog_input;
		`PIDSR_SRC_CURR: fb_mux = current_analog_input;
		`PIDSR_SRC_COMM: fb_mux = comm_freq_cmd;
		default: fb_mux = 16'h0000;
		endcase
	end

	// Feedback times calibration gain, in 0.01 units
	wire signed [31:0] fbk_p;
	pidsr_mul #(.AW(16), .BW(16)) u_fbk (
		.a({1'b0, fb_r[15:1]}),
		.b({6'h00, fbgain_r}),
		.p(fbk_p)
	);
	// Low feedback bit restored after the shifted product
	wire signed [31:0] fbk_full = (fbk_p <<< 1) +
		(fb_r[0] ? {22'h000000, fbgain_r} : 32'h00000000);

	// Error times proportional gain
	wire signed [47:0] p_p;
	pidsr_mul #(.AW(32), .BW(16)) u_prop (
		.a(err_r),
		.b({9'h000, pgain_r}),
		.p(p_p)
	);

	// Final scale of the correction back to counts
	wire signed [65:0] out_p;
	pidsr_mul #(.AW(48), .BW(18)) u_out (
		.a(sum_r),
		.b(`PIDSR_OUT_K),
		.p(out_p)
	);
	wire signed [33:0] delta = out_p[`PIDSR_OUT_SH+33:`PIDSR_OUT_SH];
	wire signed [34:0] fsum = {19'h00000, cmd_r} + {delta[33], delta};

	// Derivative source: error, or feedback in the same 0.01 scale
	wire fb_d = (mode == `PIDSR_MODE_FB) || (mode == `PIDSR_MODE_FBREV);
	wire rev_d = (mode == `PIDSR_MODE_DEVREV) ||
		(mode == `PIDSR_MODE_FBREV);
	wire signed [31:0] dsig = fb_d ? fbk_r : err_r;
	wire signed [31:0] ddiff = dsig - dprev_r;

	// Integral step with saturation
	wire signed [32:0] isum = {integ_r[31], integ_r} + {err_r[31], err_r};
	wire signed [32:0] isat = (isum > $signed(`PIDSR_IMAX)) ?
		`PIDSR_IMAX : (isum < $signed(`PIDSR_IMIN)) ? `PIDSR_IMIN : isum;

	// Regulation enable
	wire run_ok = (fsrc == `PIDSR_FSRC_PID) &&
		(mode != `PIDSR_MODE_OFF) &&
		(mode <= `PIDSR_MODE_FBREV) &&
		(sp_sel != fb_sel);

	// Write merge under byte enables
	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] sel;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				wmerge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
			end
		end
	endfunction
	wire [31:0] w_ctrl = wmerge(ctrl_r, wb_dat_i, wb_sel_i);
	wire [31:0] w_kpct = wmerge({22'h000000, kpct_r}, wb_dat_i, wb_sel_i);
	wire [31:0] w_fbg = wmerge({22'h000000, fbgain_r}, wb_dat_i, wb_sel_i);
	wire [31:0] w_pg = wmerge({25'h0000000, pgain_r}, wb_dat_i, wb_sel_i);
	wire [31:0] w_it = wmerge({16'h0000, itime_r}, wb_dat_i, wb_sel_i);
	wire [31:0] w_dt = wmerge({22'h000000, dtime_r}, wb_dat_i, wb_sel_i);

	// Wishbone slave: one ack per request, registers and read data
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			ctrl_r <= `PIDSR_RST_CTRL;
			kpct_r <= `PIDSR_RST_KPCT;
			fbgain_r <= `PIDSR_RST_FBGAIN;
			pgain_r <= `PIDSR_RST_PGAIN;
			itime_r <= `PIDSR_RST_ITIME;
			dtime_r <= `PIDSR_RST_DTIME;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req && wb_we_i) begin
				case (wb_adr_i)
				`PIDSR_ADR_CTRL: ctrl_r <= w_ctrl & `PIDSR_CTRL_MASK;
				`PIDSR_ADR_KPCT: kpct_r <= (w_kpct > `PIDSR_MAX_KPCT) ?
					`PIDSR_MAX_KPCT : w_kpct[9:0];
				`PIDSR_ADR_FBGAIN: fbgain_r <= (w_fbg > `PIDSR_MAX_FBGAIN) ?
					`PIDSR_MAX_FBGAIN : w_fbg[9:0];
				`PIDSR_ADR_PGAIN: pgain_r <= (w_pg > `PIDSR_MAX_PGAIN) ?
					`PIDSR_MAX_PGAIN : w_pg[6:0];
				`PIDSR_ADR_ITIME: itime_r <= w_it[15:0];
				`PIDSR_ADR_DTIME: dtime_r <= (w_dt > `PIDSR_MAX_DTIME) ?
					`PIDSR_MAX_DTIME : w_dt[9:0];
				default: ;
				endcase
			end
			if (bus_req && !wb_we_i) begin
				case (wb_adr_i)
				`PIDSR_ADR_CTRL: wb_dat_o <= ctrl_r;
				`PIDSR_ADR_KPCT: wb_dat_o <= {22'h000000, kpct_r};
				`PIDSR_ADR_FBGAIN: wb_dat_o <= {22'h000000, fbgain_r};
				`PIDSR_ADR_PGAIN: wb_dat_o <= {25'h0000000, pgain_r};
				`PIDSR_ADR_ITIME: wb_dat_o <= {16'h0000, itime_r};
				`PIDSR_ADR_DTIME: wb_dat_o <= {22'h000000, dtime_r};
				`PIDSR_ADR_STAT: wb_dat_o <= {29'h00000000, regulate_r,
					conflict_r, pid_active_r};
				`PIDSR_ADR_FOUT: wb_dat_o <= {16'h0000, freq_out_r};
				`PIDSR_ADR_ERR: wb_dat_o <= err_r;
				`PIDSR_ADR_INTEG: wb_dat_o <= integ_r;
				default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	// Control tick divider
	always @(posedge mclk or negedge resetn) begin
		if (!resetn)
			tick_cnt_r <= 32'h00000000;
		else if (tick)
			tick_cnt_r <= 32'h00000000;
		else
			tick_cnt_r <= tick_cnt_r + 32'h00000001;
	end

	// Per-tick computation sequence
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
			sp_r <= 16'h0000;
			fb_r <= 16'h0000;
			cmd_r <= 16'h0000;
			fbk_r <= 32'h00000000;
			err_r <= 32'h00000000;
			integ_r <= 32'h00000000;
			icnt_r <= 16'h0000;
			dcnt_r <= 10'h000;
			dprev_r <= 32'h00000000;
			dterm_r <= 32'h00000000;
			dvalid_r <= 1'b0;
			ppart_r <= 48'h000000000000;
			sum_r <= 48'h000000000000;
			freq_out_r <= 16'h0000;
			pid_active_r <= 1'b0;
			conflict_r <= 1'b0;
			regulate_r <= 1'b0;
		end else begin
			case (state_r)
			ST_IDLE: begin
				if (tick) begin
					sp_r <= sp_mux;
					fb_r <= fb_mux;
					cmd_r <= freq_cmd_in;
					regulate_r <= run_ok;
					conflict_r <= (sp_sel == fb_sel);
					state_r <= ST_SCALE;
				end
			end
			ST_SCALE: begin
				fbk_r <= fbk_full;
				state_r <= ST_ERR;
			end
			ST_ERR: begin
				err_r <= sp_r * `PIDSR_SP_SCALE - fbk_r;
				state_r <= ST_INT;
			end
			ST_INT: begin
				ppart_r <= p_p;
				// Integral: one error step each itime ticks
				if (!regulate_r || itime_r == 16'h0000) begin
					integ_r <= 32'h00000000;
					icnt_r <= 16'h0000;
				end else if (icnt_r >= itime_r - 16'h0001) begin
					integ_r <= isat[31:0];
					icnt_r <= 16'h0000;
				end else begin
					icnt_r <= icnt_r + 16'h0001;
				end
				// Derivative: change over dtime ticks
				if (!regulate_r || dtime_r == 10'h000) begin
					dterm_r <= 32'h00000000;
					dcnt_r <= 10'h000;
					dvalid_r <= 1'b0;
				end else if (dcnt_r >= dtime_r - 10'h001) begin
					dcnt_r <= 10'h000;
					dprev_r <= dsig;
					dvalid_r <= 1'b1;
					if (!dvalid_r)
						dterm_r <= 32'h00000000;
					else if (rev_d)
						dterm_r <= -ddiff;
					else
						dterm_r <= ddiff;
				end else begin
					dcnt_r <= dcnt_r + 10'h001;
				end
				state_r <= ST_SUM;
			end
			ST_SUM: begin
				sum_r <= ppart_r + ({{16{integ_r[31]}}, integ_r} +
					{{16{dterm_r[31]}}, dterm_r}) * `PIDSR_I_SCALE;
				state_r <= ST_OUT;
			end
			ST_OUT: begin
				pid_active_r <= regulate_r;
				if (!regulate_r)
					freq_out_r <= cmd_r;
				else if (fsum < 0)
					freq_out_r <= 16'h0000;
				else if (fsum > {19'h00000, `PIDSR_FMAX})
					freq_out_r <= `PIDSR_FMAX;
				else
					freq_out_r <= fsum[15:0];
				state_r <= ST_IDLE;
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule

// >>> tb/pidsr_monitor.sv
module pidsr_monitor #(
	parameter TICK_CYCLES = 20
) (
	input wire mclk,
	input wire resetn,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire [15:0] freq_cmd_in,
	input wire [15:0] freq_out_r,
	input wire pid_active_r
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] cnt_r;
	logic [7:0] stab_r;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// Cycles since last update, cycles of steady command
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= '0;
			stab_r <= '0;
		end else begin
			cnt_r <= ($changed(freq_out_r) || $changed(pid_active_r)) ?
				'0 : cnt_r + 1;
			stab_r <= !$stable(freq_cmd_in) ? '0 :
				(stab_r == 8'hff ? stab_r : stab_r + 1);
		end
	end
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence upd_s;
		$changed(freq_out_r) || $changed(pid_active_r);
	endsequence
	AST_ACK_PULSE: assert property (req_s |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle answer");
	AST_ACK_CAUSE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	AST_RD_UNMAPPED: assert property (req_s ##0 !wb_we_i && wb_adr_i > 8'h24
		|=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	AST_DAT_HOLD: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
		else $error("read data moved outside a read");
	AST_BYPASS_OUT: assert property (
		upd_s ##0 !pid_active_r && stab_r > 8'h08 |-> freq_out_r == freq_cmd_in)
		else $error("bypass output differs from command");
	AST_UPD_SPACING: assert property (upd_s |-> cnt_r >= TICK_CYCLES - 1)
		else $error("updates closer than one tick");
	AST_OUT_STAND: assert property (upd_s |=>
		($stable(freq_out_r) && $stable(pid_active_r)) [*8])
		else $error("output did not stand");
	AST_RST_IDLE: assert property ($rose(resetn) |->
		!wb_ack_o && freq_out_r == 16'h0 && !pid_active_r)
		else $error("outputs busy after reset");
endmodule
bind pidsr_top pidsr_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
	.mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .freq_cmd_in(freq_cmd_in),
	.freq_out_r(freq_out_r), .pid_active_r(pid_active_r));

// >>> tb/pidsr_src_model.sv
module pidsr_src_model (
	input wire mclk,
	input wire ramp,
	input wire [15:0] set_v [4],
	output logic [15:0] keypad_pot,
	output logic [15:0] voltage_analog_input,
	output logic [15:0] current_analog_input,
	output logic [15:0] comm_freq_cmd
);
	timeunit 1ns;
	timeprecision 1ps;
	// Converted levels; comm command climbs one count a clock on ramp
	always @(posedge mclk) begin
		keypad_pot <= set_v[0];
		voltage_analog_input <= set_v[1];
		current_analog_input <= set_v[2];
		comm_freq_cmd <= ramp ? comm_freq_cmd + 16'h0001 : set_v[3];
	end
endmodule

// >>> tb/tb.sv
`include "pidsr_defs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int T = 20;
	logic mclk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, ramp = 0;
	logic ack, act;
	logic [7:0] adr = '0;
	logic [31:0] wdat = '0, rd_o, rdat, q;
	logic [15:0] sv [4] = '{16'h1f40, 16'h2328, 16'h7530, 16'h61a8};
	logic [15:0] pot, volt, curr, comm, fout;
	logic [15:0] fcmd = 16'h03e8;
	int n_fail = 0;
	int compares = 0;
	always #2 mclk = ~mclk;
	pidsr_src_model src (.mclk(mclk), .ramp(ramp), .set_v(sv),
		.keypad_pot(pot), .voltage_analog_input(volt),
		.current_analog_input(curr), .comm_freq_cmd(comm));
	pidsr_top #(.TICK_CYCLES(T)) dut (.mclk(mclk), .resetn(resetn),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rd_o), .wb_ack_o(ack),
		.keypad_pot(pot), .voltage_analog_input(volt),
		.current_analog_input(curr), .comm_freq_cmd(comm),
		.freq_cmd_in(fcmd), .freq_out_r(fout), .pid_active_r(act));
	task automatic finish_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// One classic cycle, held until ack
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// Only ack or the watchdog ends a wait for ack
		do
			@(posedge mclk);
		while (ack !== 1'b1);
		rdat = rd_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, s);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk("reg", e, rdat);
	endtask
	task automatic wait_t(input int k);
		repeat (k * T) @(posedge mclk);
	endtask
	// Watchdog
	initial begin
		repeat (5000) @(posedge mclk);
		n_fail++;
		finish_test();
	end
	initial begin
		int i;
		longint e;
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		rd(`PIDSR_ADR_CTRL, 32'h10);
		rd(`PIDSR_ADR_FBGAIN, 32'h64);
		bus(1'b1, 8'h30, 32'hffffffff);
		rd(8'h30, 32'h0);
		bus(1'b1, `PIDSR_ADR_DTIME, 32'h7ff);
		rd(`PIDSR_ADR_DTIME, 32'h3e8);
		bus(1'b1, `PIDSR_ADR_DTIME, 32'h0);
		bus(1'b1, `PIDSR_ADR_KPCT, 32'h1f4);
		bus(1'b1, `PIDSR_ADR_CTRL, 32'h6010);
		// Bypass must follow a moved command
		fcmd <= 16'h0bb8;
		wait_t(3);
		chk("fout", 32'hbb8, {16'h0, fout});
		rd(`PIDSR_ADR_FOUT, 32'hbb8);
		rd(`PIDSR_ADR_STAT, 32'h0);
		fcmd <= 16'h03e8;
		bus(1'b1, `PIDSR_ADR_CTRL, 32'h0110);
		wait_t(3);
		chk("active", 32'h0, {31'h0, act});
		chk("fout", 32'h3e8, {16'h0, fout});
		// Every setpoint and feedback code, P term only
		bus(1'b1, `PIDSR_ADR_FBGAIN, 32'h14);
		bus(1'b1, `PIDSR_ADR_PGAIN, 32'h64);
		for (i = 0; i < 5; i++) begin
			bus(1'b1, `PIDSR_ADR_CTRL, 32'h6100 | (((i + 1) % 4) << 4) | i);
			wait_t(3);
			e = longint'(i == 4 ? 32765 : sv[i]) * 100 - sv[(i + 1) % 4] * 20;
			rd(`PIDSR_ADR_ERR, e[31:0]);
			e = (e * 100 * 42950) >>> 32;
			chk("fout", 32'(1000 + e), {16'h0, fout});
			chk("active", 32'h1, {31'h0, act});
			rd(`PIDSR_ADR_STAT, 32'h5);
		end
		// Integral step once per two ticks
		bus(1'b1, `PIDSR_ADR_PGAIN, 32'h0);
		bus(1'b1, `PIDSR_ADR_ITIME, 32'h2);
		bus(1'b1, `PIDSR_ADR_CTRL, 32'h6134);
		wait_t(3);
		bus(1'b0, `PIDSR_ADR_INTEG, 32'h0);
		q = rdat;
		repeat (2 * T - 3) @(posedge mclk);
		rd(`PIDSR_ADR_INTEG, q + 32'd2776500);
		// Derivative direction per mode on a climbing feedback
		bus(1'b1, `PIDSR_ADR_ITIME, 32'h0);
		bus(1'b1, `PIDSR_ADR_CTRL, 32'h6034);
		bus(1'b1, `PIDSR_ADR_DTIME, 32'h1);
		ramp <= 1'b1;
		for (i = 1; i < 6; i++) begin
			bus(1'b1, `PIDSR_ADR_CTRL, 32'h6034 | ((i == 5 ? 2 : i) << 8));
			if (i == 5)
				bus(1'b1, `PIDSR_ADR_DTIME, 32'h2);
			wait_t(4);
			e = longint'(fout) - 1000 - (i == 1 || i == 4 ? -4 : (i == 5 ? 8 : 4));
			compares++;
			if ($isunknown(fout) || e < -1 || e > 1) begin
				n_fail++;
				$display("mismatch dterm exp %0d got %0d", i, fout);
			end
		end
		// Undefined mode 5 must act as bypass
		bus(1'b1, `PIDSR_ADR_CTRL, 32'h6534);
		wait_t(3);
		chk("active", 32'h0, {31'h0, act});
		chk("fout", 32'h3e8, {16'h0, fout});
		finish_test();
	end
endmodule
